//--- hw/bc_uart_consts.svh
`ifndef BC_UART_CONSTS_SVH
`define BC_UART_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_RATE 4'h4
`define REG_STATUS 4'h8
`define REG_TXDATA 4'hC
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_CONN 0
`define CTRL_READY 1
`define CTRL_WAIT 2
`define CTRL_XFER 3
`define CTRL_FWUPD 4
`define CTRL_SPD_LO 5
`define CTRL_SPD_HI 6
`define CTRL_DBG_EN 7
`define CTRL_TGT_FAST 8
`define CTRL_DBG_ACT 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000
// ----------------------------------------
// Command line rates
// ----------------------------------------
`define CMD_HIZ 32'h0000_2594
`define CMD_NOFLOW 32'h0000_2595
`define CMD_FLOW 32'h0000_2596
`define CMD_SUPPLY 32'h0000_2597
`define CMD_PARITY 32'h0000_2599
`define RATE_4800 32'h0000_12C0
`define RATE_19200 32'h0000_4B00
`define RATE_28800 32'h0000_7080
`define RATE_57600 32'h0000_E100
`define RATE_115200 32'h0001_C200
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ 250000
`define DBG_SLOW_KHZ 200
`define DBG_MED_KHZ 400
`define DBG_FAST_KHZ 600
`define DBG_HALF(khz) (`CLK_KHZ / (2 * (khz)))
`define BLINK_MS 250
`define BLINK_CYCLES (`BLINK_MS * `CLK_KHZ)
`define FIFO_DEPTH 8
`endif

//--- hw/bc_uart_pkg.sv
package bc_uart_pkg;
  typedef struct packed {
    logic hiz;
    logic flow;
    logic par_even;
    logic supply;
  } uart_cfg_t;
  typedef enum logic [5:0] {
    LED_OFF = 6'b000001,
    LED_READY = 6'b000010,
    LED_WAIT = 6'b000100,
    LED_XFER = 6'b001000,
    LED_ERROR = 6'b010000,
    LED_FWUPD = 6'b100000
  } led_state_t;
endpackage

//--- hw/probe_backchannel_uart_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bc_uart_consts.svh"

// ----------------------------------------
// Transmit buffer
// ----------------------------------------
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("stream_fifo depth must be a power of two");
    end
  end

  assign out_valid_o = wr_ptr != rd_ptr;
  assign in_ready_o = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module probe_backchannel_uart_ctrl #(
  parameter int BLINK_CYCLES = `BLINK_CYCLES,
  parameter bit HANDSHAKE_REV = 1'b1,
  parameter bit SUPPLY_LED_REV = 1'b1,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overcurrent_i,
  input wire logic energy_supply_i,
  input wire logic target_rts_n_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [31:0] line_rate_o,
  output logic line_rate_valid_o,
  output logic bc_pins_oe_n_o,
  output logic flow_ctrl_o,
  output logic parity_even_o,
  output logic target_supply_o,
  output logic two_wire_debug_clock_o,
  output logic power_led_o,
  output logic mode_led_o,
  output logic supply_indicator_led_o
);
  initial begin
    if (BLINK_CYCLES < 2 || FIFO_DEPTH < 2) begin
      $error("blink period or buffer depth too small");
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic aw_got;
  logic w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [`CTRL_WIDTH-1:0] ctrl;
  logic fifo_in_ready;
  logic fifo_push;
  bc_uart_pkg::uart_cfg_t cfg;
  logic fault;
  logic rate_lossfree;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `REG_CTRL) || (a == `REG_RATE) || (a == `REG_STATUS) || (a == `REG_TXDATA);
  endfunction

  // A data write waits here while the buffer is full, so the master feels
  // the back-pressure instead of losing bytes.
  assign fifo_push = aw_got && w_got && !s_axi_bvalid && aw_addr == `REG_TXDATA && w_strb[0];
  assign do_write = aw_got && w_got && !s_axi_bvalid && (!fifo_push || fifo_in_ready);
  assign s_axi_awready = !aw_got;
  assign s_axi_wready = !w_got;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_got) begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && !w_got) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr[3:2] == 2'h0) begin
        s_axi_rdata <= {22'h0, ctrl};
      end else if (s_axi_araddr[3:2] == 2'h1) begin
        s_axi_rdata <= line_rate_o;
      end else if (s_axi_araddr[3:2] == 2'h2) begin
        s_axi_rdata <= {22'h0, energy_supply_i, !fifo_in_ready, !tx_valid_o,
                        rate_lossfree, line_rate_valid_o, fault, cfg.supply,
                        cfg.par_even, cfg.flow, cfg.hiz};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (do_write && aw_addr == `REG_CTRL) begin
      if (w_strb[0]) begin
        ctrl[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        ctrl[`CTRL_WIDTH-1:8] <= w_data[`CTRL_WIDTH-1:8];
      end
    end
  end

  // ----------------------------------------
  // Line rate and mode commands
  // ----------------------------------------
  logic rate_wr;
  assign rate_wr = do_write && aw_addr == `REG_RATE && (&w_strb);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= '{hiz: 1'b0, flow: 1'b0, par_even: 1'b0, supply: 1'b1};
      line_rate_o <= 32'h0000_0000;
      line_rate_valid_o <= 1'b0;
    end else if (rate_wr) begin
      // A command leaves the previous genuine rate unusable until a new one.
      if (w_data == `CMD_HIZ) begin
        cfg.hiz <= 1'b1;
        line_rate_valid_o <= 1'b0;
      end else if (w_data == `CMD_NOFLOW) begin
        cfg.hiz <= 1'b0;
        cfg.flow <= 1'b0;
        cfg.par_even <= 1'b0;
        line_rate_valid_o <= 1'b0;
      end else if (w_data == `CMD_FLOW) begin
        if (HANDSHAKE_REV) begin
          cfg.hiz <= 1'b0;
          cfg.flow <= 1'b1;
          cfg.par_even <= 1'b0;
        end
        line_rate_valid_o <= 1'b0;
      end else if (w_data == `CMD_SUPPLY) begin
        cfg.supply <= 1'b1;
        line_rate_valid_o <= 1'b0;
      end else if (w_data == `CMD_PARITY) begin
        cfg.hiz <= 1'b0;
        cfg.flow <= 1'b0;
        cfg.par_even <= 1'b1;
        line_rate_valid_o <= 1'b0;
      end else begin
        line_rate_o <= w_data;
        line_rate_valid_o <= 1'b1;
      end
    end
  end

  assign bc_pins_oe_n_o = cfg.hiz;
  assign flow_ctrl_o = cfg.flow;
  assign parity_even_o = cfg.par_even;
  assign target_supply_o = cfg.supply && !fault;

  // Rates from 4800 to 19200 are always safe; above that the table narrows fast.
  always_comb begin
    if (line_rate_o >= `RATE_4800 && line_rate_o <= `RATE_19200) begin
      rate_lossfree = 1'b1;
    end else if (line_rate_o == `RATE_115200) begin
      rate_lossfree = cfg.flow && ctrl[`CTRL_TGT_FAST];
    end else if (line_rate_o > `RATE_28800 && line_rate_o <= `RATE_57600) begin
      rate_lossfree = cfg.flow;
    end else if (line_rate_o > `RATE_19200 && line_rate_o <= `RATE_28800) begin
      rate_lossfree = cfg.flow || ctrl[`CTRL_TGT_FAST] || !ctrl[`CTRL_DBG_ACT];
    end else begin
      rate_lossfree = 1'b0;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  logic fifo_out_valid;
  logic drain_ok;
  assign drain_ok = line_rate_valid_o && !cfg.hiz && (!cfg.flow || !target_rts_n_i);
  assign tx_valid_o = fifo_out_valid && drain_ok;

  stream_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_data_i(w_data[7:0]),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(tx_data_o),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_ready_i && drain_ok)
  );

  // ----------------------------------------
  // Debug clock
  // ----------------------------------------
  localparam logic [9:0] HALF_SLOW = 10'(`DBG_HALF(`DBG_SLOW_KHZ));
  localparam logic [9:0] HALF_MED = 10'(`DBG_HALF(`DBG_MED_KHZ));
  localparam logic [9:0] HALF_FAST = 10'(`DBG_HALF(`DBG_FAST_KHZ));
  logic [9:0] dbg_cnt;
  logic [9:0] dbg_half;

  always_comb begin
    case (ctrl[`CTRL_SPD_HI:`CTRL_SPD_LO])
      2'h1: dbg_half = HALF_MED;
      2'h2: dbg_half = HALF_FAST;
      default: dbg_half = HALF_SLOW;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_cnt <= 10'h000;
      two_wire_debug_clock_o <= 1'b0;
    end else if (!ctrl[`CTRL_DBG_EN]) begin
      dbg_cnt <= 10'h000;
      two_wire_debug_clock_o <= 1'b0;
    end else if (dbg_cnt >= dbg_half - 10'h001) begin
      dbg_cnt <= 10'h000;
      two_wire_debug_clock_o <= !two_wire_debug_clock_o;
    end else begin
      dbg_cnt <= dbg_cnt + 10'h001;
    end
  end

  // ----------------------------------------
  // Status LEDs
  // ----------------------------------------
  logic [31:0] blink_cnt;
  logic blink;
  bc_uart_pkg::led_state_t led_state;

  // Only a reset clears the fault, standing in for a power cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else if (overcurrent_i) begin
      fault <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt <= 32'h0000_0000;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_state <= bc_uart_pkg::LED_OFF;
    end else if (fault) begin
      led_state <= bc_uart_pkg::LED_ERROR;
    end else if (ctrl[`CTRL_FWUPD]) begin
      led_state <= bc_uart_pkg::LED_FWUPD;
    end else if (!ctrl[`CTRL_CONN] || !ctrl[`CTRL_READY]) begin
      led_state <= bc_uart_pkg::LED_OFF;
    end else if (ctrl[`CTRL_XFER] && ctrl[`CTRL_DBG_ACT]) begin
      led_state <= bc_uart_pkg::LED_XFER;
    end else if (ctrl[`CTRL_WAIT]) begin
      led_state <= bc_uart_pkg::LED_WAIT;
    end else begin
      led_state <= bc_uart_pkg::LED_READY;
    end
  end

  always_comb begin
    case (led_state)
      bc_uart_pkg::LED_READY: begin
        power_led_o = 1'b1;
        mode_led_o = 1'b0;
      end
      bc_uart_pkg::LED_WAIT: begin
        power_led_o = 1'b1;
        mode_led_o = 1'b1;
      end
      bc_uart_pkg::LED_XFER: begin
        power_led_o = 1'b1;
        mode_led_o = blink;
      end
      bc_uart_pkg::LED_ERROR: begin
        power_led_o = 1'b0;
        mode_led_o = 1'b1;
      end
      bc_uart_pkg::LED_FWUPD: begin
        power_led_o = blink;
        mode_led_o = blink;
      end
      default: begin
        power_led_o = 1'b0;
        mode_led_o = 1'b0;
      end
    endcase
  end

  // The indicator goes dark when the energy supply takes over the target.
  assign supply_indicator_led_o = SUPPLY_LED_REV && ctrl[`CTRL_CONN] && target_supply_o
                                  && !energy_supply_i;
endmodule
`default_nettype wire

//--- tb/probe_backchannel_uart_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "bc_uart_consts.svh"
module probe_backchannel_uart_ctrl_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic overcurrent_i,
  input wire logic energy_supply_i,
  input wire logic target_rts_n_i,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [31:0] line_rate_o,
  input wire logic line_rate_valid_o,
  input wire logic bc_pins_oe_n_o,
  input wire logic flow_ctrl_o,
  input wire logic parity_even_o,
  input wire logic target_supply_o,
  input wire logic power_led_o,
  input wire logic mode_led_o,
  input wire logic supply_indicator_led_o
);
  logic rate_wr;
  logic is_cmd;
  logic [31:0] wd_q;
  // Only same-edge address and data writes are watched; split writes go unchecked here.
  assign rate_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == `REG_RATE && s_axi_wstrb == 4'hF;
  assign is_cmd = s_axi_wdata inside {`CMD_HIZ, `CMD_NOFLOW, `CMD_FLOW, `CMD_SUPPLY, `CMD_PARITY};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_q <= 32'h0000_0000;
    end else if (rate_wr) begin
      wd_q <= s_axi_wdata;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_hiz_cmd: assert property (rate_wr && s_axi_wdata == `CMD_HIZ |-> ##[1:2] bc_pins_oe_n_o)
    else $error("pins not released after hiz command");
  a_noflow_cmd: assert property (rate_wr && s_axi_wdata == `CMD_NOFLOW |-> ##[1:2]
    (!bc_pins_oe_n_o && !flow_ctrl_o && !parity_even_o)) else $error("plain mode not set");
  a_flow_cmd: assert property (rate_wr && s_axi_wdata == `CMD_FLOW |-> ##[1:2] flow_ctrl_o)
    else $error("handshake mode not set");
  a_parity_cmd: assert property (rate_wr && s_axi_wdata == `CMD_PARITY |-> ##[1:2]
    (parity_even_o && !flow_ctrl_o)) else $error("parity mode not set");
  a_cmd_no_rate: assert property (rate_wr && is_cmd |-> ##[1:2] !line_rate_valid_o)
    else $error("command became a line rate");
  a_rate_store: assert property (rate_wr && !is_cmd |=> ##[0:1]
    (line_rate_valid_o && line_rate_o == wd_q)) else $error("genuine rate not stored");
  a_tx_gate: assert property (tx_valid_o |->
    (line_rate_valid_o && !bc_pins_oe_n_o && (!flow_ctrl_o || !target_rts_n_i)))
    else $error("data offered while blocked");
  a_fault_trip: assert property (overcurrent_i |-> ##[1:3]
    (!target_supply_o && !power_led_o && mode_led_o)) else $error("fault not shown");
  a_fault_hold: assert property (!target_supply_o |=> !target_supply_o)
    else $error("fault cleared without reset");
  a_ind_energy: assert property (supply_indicator_led_o |-> !energy_supply_i)
    else $error("indicator lit on energy supply");
  c_tx_move: cover property (tx_valid_o && tx_ready_i);
  c_flow_cmd: cover property (rate_wr && s_axi_wdata == `CMD_FLOW);
  c_fault: cover property ($fell(target_supply_o));
endmodule
bind probe_backchannel_uart_ctrl probe_backchannel_uart_ctrl_chk probe_backchannel_uart_ctrl_chk_inst (
  .ref_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .overcurrent_i, .energy_supply_i, .target_rts_n_i, .tx_valid_o,
  .tx_ready_i, .line_rate_o, .line_rate_valid_o, .bc_pins_oe_n_o, .flow_ctrl_o, .parity_even_o,
  .target_supply_o, .power_led_o, .mode_led_o, .supply_indicator_led_o);
`default_nettype wire

//--- tb/target_uart_model.sv
`timescale 1ns/1ps
`default_nettype none
module target_uart_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic stall_i,
  output logic tx_ready_o,
  output logic rts_n_o
);
  logic [7:0] rx_q[$];
  // A stalled target holds its active-low ready-to-receive line high.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      rts_n_o <= 1'b1;
    end else begin
      tx_ready_o <= !stall_i;
      rts_n_o <= stall_i;
    end
  end
  always @(posedge ref_clk_i) begin
    if (!rst_i && tx_valid_i && tx_ready_o) begin
      rx_q.push_back(tx_data_i);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_probe_backchannel_uart_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bc_uart_consts.svh"
module tb_probe_backchannel_uart_ctrl;
  logic ref_clk_i, rst_i, stall;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, line_rate_o, q, exp_rate;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, line_rate_valid_o;
  logic overcurrent_i, energy_supply_i, target_rts_n_i, tx_valid_o, tx_ready_i;
  logic [7:0] tx_data_o;
  logic bc_pins_oe_n_o, flow_ctrl_o, parity_even_o, target_supply_o, two_wire_debug_clock_o;
  logic power_led_o, mode_led_o, supply_indicator_led_o, p0, m0;
  int num_errors, cmp_count, pt, mt, h;
  logic [31:0] rates[9] = '{`CMD_HIZ, `RATE_4800, `CMD_NOFLOW, `CMD_FLOW, `RATE_115200,
    `CMD_PARITY, `CMD_SUPPLY, `RATE_19200, `CMD_NOFLOW};
  logic [4:0] cfgx[9] = '{5'h12, 5'h13, 5'h02, 5'h0A, 5'h0B, 5'h06, 5'h06, 5'h07, 5'h02};
  logic [9:0] ctrls[6] = '{10'h000, 10'h001, 10'h003, 10'h007, 10'h20B, 10'h013};
  logic [3:0] leds[6] = '{4'h0, 4'h0, 4'h8, 4'hC, 4'h9, 4'h3};
  int half[3] = '{625, 312, 208};
  probe_backchannel_uart_ctrl #(.BLINK_CYCLES(4)) probe_backchannel_uart_ctrl_inst (
    .ref_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .overcurrent_i, .energy_supply_i, .target_rts_n_i, .tx_data_o, .tx_valid_o, .tx_ready_i,
    .line_rate_o, .line_rate_valid_o, .bc_pins_oe_n_o, .flow_ctrl_o, .parity_even_o,
    .target_supply_o, .two_wire_debug_clock_o, .power_led_o, .mode_led_o, .supply_indicator_led_o);
  target_uart_model target_uart_model_inst (.ref_clk_i, .rst_i, .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .stall_i(stall), .tx_ready_o(tx_ready_i), .rts_n_o(target_rts_n_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  // Handshakes are judged on negedge snapshots, which equal the values at the next rising edge.
  task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
    bit ta, tw, tr;
    @(posedge ref_clk_i);
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    tr = 1'b0;
    for (int n = 0; n < 100 && !tr; n++) begin
      @(negedge ref_clk_i);
      ta = we ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tr = we ? s_axi_bvalid : s_axi_rvalid;
      q = we ? {30'h0, s_axi_bresp} : s_axi_rdata;
      @(posedge ref_clk_i);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(tr, 1'b1);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    num_errors++;
    $display("[ERR] %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    {rst_i, stall, overcurrent_i, energy_supply_i} = 4'b1000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    exp_rate = 32'h0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk({bc_pins_oe_n_o, flow_ctrl_o, parity_even_o, target_supply_o, line_rate_valid_o}, 5'h02);
    chk({power_led_o, mode_led_o}, 2'h0);
    chk(line_rate_o, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      bus(1, `REG_RATE, rates[i], 4'hF);
      chk(q, 32'h0);
      cyc(2);
      chk({bc_pins_oe_n_o, flow_ctrl_o, parity_even_o, target_supply_o, line_rate_valid_o}, cfgx[i]);
      if (cfgx[i][0]) exp_rate = rates[i];
      chk(line_rate_o, exp_rate);
    end
    $display("rate command test done");
    bus(1, `REG_RATE, `CMD_HIZ, 4'h3);
    cyc(2);
    chk(bc_pins_oe_n_o, 1'b0);
    // Every word of the small map is decoded, so an unaligned offset aliases its word.
    bus(1, 4'h2, 32'h0000_00FF, 4'hF);
    chk(q, 32'h0);
    bus(0, 4'h2, 32'h0, 4'h0);
    chk(q, 32'hFF);
    $display("refusal test done");
    bus(1, `REG_RATE, `RATE_19200, 4'hF);
    stall <= 1'b1;
    for (int i = 0; i < 8; i++) bus(1, `REG_TXDATA, 32'hA0 + i, 4'hF);
    bus(0, `REG_STATUS, 32'h0, 4'h0);
    chk(q[8], 1'b1);
    stall <= 1'b0;
    for (int n = 0; n < 100 && target_uart_model_inst.rx_q.size() < 8; n++) cyc(0);
    for (int i = 0; i < 8; i++) chk(target_uart_model_inst.rx_q[i], 8'hA0 + i);
    bus(0, `REG_STATUS, 32'h0, 4'h0);
    chk(q[8:7], 2'b01);
    bus(1, `REG_RATE, `CMD_FLOW, 4'hF);
    bus(1, `REG_RATE, `RATE_115200, 4'hF);
    stall <= 1'b1;
    bus(1, `REG_TXDATA, 32'h5A, 4'hF);
    cyc(8);
    chk(tx_valid_o, 1'b0);
    @(posedge ref_clk_i) stall <= 1'b0;
    cyc(8);
    chk(target_uart_model_inst.rx_q[$], 8'h5A);
    $display("stream test done");
    for (int i = 0; i < 6; i++) begin
      bus(1, `REG_CTRL, {22'h0, ctrls[i]}, 4'hF);
      cyc(3);
      {pt, mt, p0, m0} = {32'h0, 32'h0, power_led_o, mode_led_o};
      repeat (16) begin
        @(negedge ref_clk_i);
        pt += (power_led_o !== p0);
        mt += (mode_led_o !== m0);
        {p0, m0} = {power_led_o, mode_led_o};
      end
      chk({pt != 0, mt != 0}, leds[i][1:0]);
      if (!leds[i][1]) chk(power_led_o, leds[i][3]);
      if (!leds[i][0]) chk(mode_led_o, leds[i][2]);
    end
    bus(1, `REG_CTRL, 32'h3, 4'hF);
    cyc(2);
    chk(supply_indicator_led_o, 1'b1);
    @(posedge ref_clk_i) energy_supply_i <= 1'b1;
    cyc(2);
    chk(supply_indicator_led_o, 1'b0);
    $display("led test done");
    for (int s = 0; s < 3; s++) begin
      bus(1, `REG_CTRL, 32'h83 | (s << 5), 4'hF);
      for (int n = 0; n < 2000 && two_wire_debug_clock_o !== 1'b1; n++) cyc(0);
      for (int n = 0; n < 2000 && two_wire_debug_clock_o !== 1'b0; n++) cyc(0);
      for (int n = 0; n < 2000 && two_wire_debug_clock_o !== 1'b1; n++) cyc(0);
      for (h = 0; h < 2000 && two_wire_debug_clock_o === 1'b1; h++) cyc(0);
      chk(h, half[s]);
    end
    $display("debug clock test done");
    bus(1, `REG_CTRL, 32'h3, 4'hF);
    @(posedge ref_clk_i) overcurrent_i <= 1'b1;
    @(posedge ref_clk_i) overcurrent_i <= 1'b0;
    cyc(4);
    chk({target_supply_o, power_led_o, mode_led_o}, 3'b001);
    bus(1, `REG_RATE, `CMD_SUPPLY, 4'hF);
    cyc(2);
    chk(target_supply_o, 1'b0);
    @(posedge ref_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk({target_supply_o, bc_pins_oe_n_o, line_rate_valid_o}, 3'b100);
    $display("fault test done");
    wrap_up();
  end
endmodule
`default_nettype wire
